// ===== bps_pkg.sv
// package: constants and carriers for the backup power status block
package bps_pkg;

  // widths
  localparam int STAMP_W = 40;  // five bytes: sec, min, hour, date, month/year
  localparam int ADDR_W  = 4;
  localparam int DATA_W  = 8;

  // register offsets (byte wide)
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK   = 4'h1;
  localparam logic [3:0] REG_CTRL   = 4'h2;
  localparam logic [3:0] REG_COMP   = 4'h3;
  localparam logic [3:0] REG_BATCFG = 4'h4;
  localparam logic [3:0] REG_MODE   = 4'h5;
  localparam logic [3:0] REG_V2B0   = 4'h6;  // five bytes 6..a
  localparam logic [3:0] REG_B2V0   = 4'hb;  // five bytes b..f

  // status bit positions
  localparam int ST_TPF   = 0;
  localparam int ST_BAT2  = 1;
  localparam int ST_BAT1  = 2;
  localparam int ST_VLOW  = 3;
  localparam int ST_TOBAK = 4;
  localparam int ST_TOMAIN = 5;
  localparam int N_EVT    = 6;

  // control bit positions
  localparam int CT_STAMP_CLR = 0;  // stamp_clear, self clearing
  localparam int CT_SCLEN = 1;  // serial pins enable in backup; not read by the logic, serial port is always off in backup
  localparam int CT_IOEN  = 2;  // other io enable in backup
  localparam int CP_TEMP_SENSE = 7;  // temp_sense_enable
  localparam int CP_BAK_TEMP   = 6;  // backup_temp_sense_enable

  // reset values
  localparam logic [7:0] RST_CTRL   = 8'h04;
  localparam logic [7:0] RST_COMP   = 8'h00;
  localparam logic [7:0] RST_BATCFG = 8'h00;
  localparam logic [7:0] RST_MASK   = 8'h00;

  // comparator samples needed before a mode change
  localparam logic [1:0] STABLE_N = 2'h2;

  typedef enum logic [1:0] {
    BPS_MAIN   = 2'b00,
    BPS_TOBAK  = 2'b01,
    BPS_BACKUP = 2'b11,
    BPS_TOMAIN = 2'b10
  } bps_mode_e;

  typedef struct packed {
    logic below_bat_hys;  // main < backup - hysteresis
    logic below_trip;     // main < trip level
    logic above_bat_hys;  // main > backup + hysteresis
    logic above_trip_hys; // main > trip + hysteresis
    logic main_low;       // brownout comparator
    logic bat_below_hi;   // battery under upper threshold
    logic bat_below_lo;   // battery under lower threshold
  } bps_cmp_s;

  typedef struct packed {
    bps_mode_e               mode;
    bps_cmp_s                cmp_a;
    bps_cmp_s                cmp_b;
    logic [1:0]              stable;
    logic [N_EVT-1:0]        status;
    logic [N_EVT-1:0]        mask;
    logic [7:0]              ctrl;
    logic [7:0]              comp;
    logic [7:0]              batcfg;
    logic [STAMP_W-1:0]      v2b;
    logic [STAMP_W-1:0]      b2v;
    logic                    v2b_held;
    logic [DATA_W-1:0]       rdata;
    logic                    irq;
    logic                    serial_en;
    logic                    io_en;
    logic                    temp_run;
    logic                    bat_meas;
  } bps_state_s;

endpackage

// ===== bps_power_status.sv
// backup power switchover, stamps and supply status flags
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
// Overview of operation
// - enter backup only when main below backup minus hysteresis and below trip.
// - return to main when either upper comparator condition holds.
// - serial host interface disabled and ignored while in backup mode.
// - other io stays active in backup unless control bit disables it.
// - copy time and date into return stamp on each return, into entry stamp on an entry while not held.
// - entry stamp keeps earliest event, return stamp keeps most recent.
// - entry stamp held until software sets stamp_clear, which clears both stamps.
// - temperature compensation runs in backup only when backup enable bit set.
// - flag total power failure when powering up after losing all supplies.
// - brownout comparator against selected level sets main_supply_low_flag.
// - brownout alone never disables the serial interface.
// - first battery flag between thresholds; both flags below lower threshold.
// - battery monitor frozen during backup mode.
module bps_power_status (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // timebase tick and current time
  input  wire logic                       tick,
  input  wire logic [bps_pkg::STAMP_W-1:0] time_now,
  // comparators and power-up info
  input  wire bps_pkg::bps_cmp_s          cmp_in,
  input  wire logic                       all_power_lost,
  // register port
  input  wire logic [bps_pkg::ADDR_W-1:0] addr,
  input  wire logic [bps_pkg::DATA_W-1:0] wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic      [bps_pkg::DATA_W-1:0] rdata,
  // status outputs
  output logic                            irq,
  output logic                            backup_mode,
  output logic                            serial_en,
  output logic                            io_en,
  output logic                            temp_run,
  output logic                            bat_meas,
  output logic      [2:0]                 brownout_level
);

  bps_pkg::bps_state_s s_r;
  bps_pkg::bps_state_s s_nxt;
  logic [bps_pkg::N_EVT-1:0] evt;
  logic want_bak;
  logic want_main;
  logic in_bak;
  logic bus_ok;
  logic [bps_pkg::DATA_W-1:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt     = s_r;
    evt       = '0;
    rd_mux    = '0;
    in_bak    = (s_r.mode == bps_pkg::BPS_BACKUP) || (s_r.mode == bps_pkg::BPS_TOBAK);
    bus_ok    = !in_bak;
    want_bak  = s_r.cmp_b.below_bat_hys && s_r.cmp_b.below_trip;
    want_main = s_r.cmp_b.above_bat_hys || s_r.cmp_b.above_trip_hys;
    // two stage sampling on each timebase tick
    if (tick) begin
      s_nxt.cmp_a = cmp_in;
      s_nxt.cmp_b = s_r.cmp_a;
    end
    // count stable samples of the wanted change
    if (tick) begin
      if ((s_r.mode == bps_pkg::BPS_MAIN && want_bak) ||
          (s_r.mode == bps_pkg::BPS_BACKUP && want_main)) begin
        if (s_r.stable != bps_pkg::STABLE_N)
          s_nxt.stable = s_r.stable + 2'h1;
      end else begin
        s_nxt.stable = '0;
      end
    end
    // clear before the mode logic so a stamp taken in the same cycle wins
    s_nxt.ctrl[bps_pkg::CT_STAMP_CLR] = 1'b0;
    if (s_r.ctrl[bps_pkg::CT_STAMP_CLR]) begin
      s_nxt.v2b      = '0;
      s_nxt.b2v      = '0;
      s_nxt.v2b_held = 1'b0;
    end
    case (s_r.mode)
      bps_pkg::BPS_MAIN: begin
        if (tick && want_bak && s_r.stable == bps_pkg::STABLE_N) begin
          s_nxt.mode = bps_pkg::BPS_TOBAK;
        end
      end
      bps_pkg::BPS_TOBAK: begin
        // only the first entry is kept until cleared
        if (!s_r.v2b_held) begin
          s_nxt.v2b      = time_now;
          s_nxt.v2b_held = 1'b1;
        end
        evt[bps_pkg::ST_TOBAK] = 1'b1;
        s_nxt.mode   = bps_pkg::BPS_BACKUP;
        s_nxt.stable = '0;
      end
      bps_pkg::BPS_BACKUP: begin
        if (tick && want_main && s_r.stable == bps_pkg::STABLE_N) begin
          s_nxt.mode = bps_pkg::BPS_TOMAIN;
        end
      end
      bps_pkg::BPS_TOMAIN: begin
        s_nxt.b2v = time_now;
        evt[bps_pkg::ST_TOMAIN] = 1'b1;
        s_nxt.mode   = bps_pkg::BPS_MAIN;
        s_nxt.stable = '0;
      end
      default: begin
        s_nxt.mode = bps_pkg::BPS_MAIN;
      end
    endcase
    // supply monitors
    evt[bps_pkg::ST_TPF]  = all_power_lost;
    evt[bps_pkg::ST_VLOW] = s_r.cmp_b.main_low;
    // battery monitor only sampled on a host requested measurement in main mode
    if (s_r.bat_meas && !in_bak) begin
      evt[bps_pkg::ST_BAT1] = s_r.cmp_b.bat_below_hi || s_r.cmp_b.bat_below_lo;
      evt[bps_pkg::ST_BAT2] = s_r.cmp_b.bat_below_lo;
    end
    s_nxt.bat_meas = s_r.comp[bps_pkg::CP_TEMP_SENSE] && !in_bak;
    // register writes, bus ignored in backup
    if (wr && bus_ok) begin
      case (addr)
        bps_pkg::REG_STATUS: s_nxt.status = s_r.status & ~wdata[bps_pkg::N_EVT-1:0];
        bps_pkg::REG_MASK:   s_nxt.mask   = wdata[bps_pkg::N_EVT-1:0];
        bps_pkg::REG_CTRL:   s_nxt.ctrl   = wdata;
        bps_pkg::REG_COMP:   s_nxt.comp   = wdata;
        bps_pkg::REG_BATCFG: s_nxt.batcfg = wdata;
        default: begin
        end
      endcase
    end
    // set wins over clear
    s_nxt.status = s_nxt.status | evt;
    // register reads
    case (addr)
      bps_pkg::REG_STATUS: rd_mux = {2'h0, s_r.status};
      bps_pkg::REG_MASK:   rd_mux = {2'h0, s_r.mask};
      bps_pkg::REG_CTRL:   rd_mux = s_r.ctrl;
      bps_pkg::REG_COMP:   rd_mux = s_r.comp;
      bps_pkg::REG_BATCFG: rd_mux = s_r.batcfg;
      bps_pkg::REG_MODE:   rd_mux = {6'h00, s_r.mode};
      4'h6:  rd_mux = s_r.v2b[7:0];
      4'h7:  rd_mux = s_r.v2b[15:8];
      4'h8:  rd_mux = s_r.v2b[23:16];
      4'h9:  rd_mux = s_r.v2b[31:24];
      4'ha:  rd_mux = s_r.v2b[39:32];
      4'hb:  rd_mux = s_r.b2v[7:0];
      4'hc:  rd_mux = s_r.b2v[15:8];
      4'hd:  rd_mux = s_r.b2v[23:16];
      4'he:  rd_mux = s_r.b2v[31:24];
      4'hf:  rd_mux = s_r.b2v[39:32];
      default: rd_mux = '0;
    endcase
    s_nxt.rdata = (rd && bus_ok) ? rd_mux : '0;
    s_nxt.irq   = |(s_nxt.status & s_nxt.mask);
    // outputs that depend on the next mode
    s_nxt.serial_en = (s_nxt.mode == bps_pkg::BPS_MAIN) ||
                      (s_nxt.mode == bps_pkg::BPS_TOMAIN);
    s_nxt.io_en     = !((s_nxt.mode == bps_pkg::BPS_BACKUP) &&
                        !s_nxt.ctrl[bps_pkg::CT_IOEN]);
    s_nxt.temp_run  = s_nxt.comp[bps_pkg::CP_TEMP_SENSE] &&
                      (s_nxt.serial_en || s_nxt.comp[bps_pkg::CP_BAK_TEMP]);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r           <= '0;
      s_r.mode      <= bps_pkg::BPS_MAIN;
      s_r.ctrl      <= bps_pkg::RST_CTRL;
      s_r.comp      <= bps_pkg::RST_COMP;
      s_r.batcfg    <= bps_pkg::RST_BATCFG;
      s_r.mask      <= bps_pkg::RST_MASK[bps_pkg::N_EVT-1:0];
      s_r.serial_en <= 1'b1;
      s_r.io_en     <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign rdata          = s_r.rdata;
  assign irq            = s_r.irq;
  assign backup_mode    = s_r.mode[0];
  assign serial_en      = s_r.serial_en;
  assign io_en          = s_r.io_en;
  assign temp_run       = s_r.temp_run;
  assign bat_meas       = s_r.bat_meas;
  assign brownout_level = s_r.batcfg[2:0];

endmodule

// ===== bps_checker_asserts.sv
// checker for the backup power status block
`timescale 1ns/1ps
module bps_checker (
  // clock and reset
  input wire logic                       clk,
  input wire logic                       rst,
  // register port and comparators
  input wire bps_pkg::bps_cmp_s          cmp_in,
  input wire logic [bps_pkg::ADDR_W-1:0] addr,
  input wire logic [bps_pkg::DATA_W-1:0] wdata,
  input wire logic                       wr,
  input wire logic                       rd,
  // outputs
  input wire logic [bps_pkg::DATA_W-1:0] rdata,
  input wire logic                       irq,
  input wire logic                       backup_mode,
  input wire logic                       serial_en,
  input wire logic                       bat_meas,
  input wire logic [2:0]                 brownout_level
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // window of 8 covers the two sync stages plus two stable samples
  both_conds_a: assert property ((!(cmp_in.below_bat_hys && cmp_in.below_trip))[*8]
    |=> !$rose(backup_mode)) else $error("backup entered without both conditions");
  return_main_a: assert property (((cmp_in.above_bat_hys || cmp_in.above_trip_hys)
    && !cmp_in.below_trip)[*8] |-> ##[0:4] !backup_mode) else $error("no return to main");
  serial_off_a: assert property (backup_mode[*3] |-> !serial_en)
    else $error("serial port alive in backup");
  serial_on_a: assert property (!backup_mode[*3] |-> serial_en)
    else $error("serial port off outside backup");
  bat_frozen_a: assert property (backup_mode[*3] |-> !bat_meas)
    else $error("battery monitor runs in backup");
  level_sel_a: assert property (wr && addr == bps_pkg::REG_BATCFG && !backup_mode
    |=> brownout_level == $past(wdata[2:0])) else $error("brownout level not taken");
  irq_masked_a: assert property (wr && addr == bps_pkg::REG_MASK && wdata == 8'h00
    && !backup_mode |=> !irq) else $error("irq with empty mask");
  rdata_idle_a: assert property (!rd |=> rdata == 8'h00) else $error("read data without read");
  cover property ($rose(backup_mode));
  cover property ($fell(backup_mode));
  cover property ($rose(irq));
endmodule
bind bps_power_status bps_checker u_chk (.clk(clk), .rst(rst), .cmp_in(cmp_in), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .backup_mode(backup_mode),
  .serial_en(serial_en), .bat_meas(bat_meas), .brownout_level(brownout_level));

// ===== bps_host.sv
// host model driving the register port
`timescale 1ns/1ps
module bps_host (
  // clock
  input  wire logic                       clk,
  // register port
  output logic      [bps_pkg::ADDR_W-1:0] addr,
  output logic      [bps_pkg::DATA_W-1:0] wdata,
  output logic                            wr,
  output logic                            rd
);
  initial {addr, wdata, wr, rd} = '0;
  // wdata after a write and addr after a read show inverted values so stale data never looks valid
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    wdata <= ~d;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    addr <= ~a;
  endtask
endmodule

// ===== bps_power_status_bench.sv
// self-checking bench for the backup power status block
`timescale 1ns/1ps
module bps_power_status_bench;
  logic clk, rst, tick, all_power_lost, wr, rd, irq, backup_mode, serial_en, io_en;
  logic temp_run, bat_meas, rd_d = 1'b0;
  logic [39:0] time_now, ta, tb, tc, td;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic [2:0] brownout_level;
  logic [31:0] seed;
  bps_pkg::bps_cmp_s cmp_in;
  logic [7:0] exp_q[$];
  int errors, tests_run;
  always #10 clk = ~clk;
  // timebase tick on every other edge so the sampling enable is really exercised
  always @(posedge clk) tick <= rst ? 1'b1 : ~tick;
  bps_power_status u_bps_power_status (.clk(clk), .rst(rst), .tick(tick),
    .time_now(time_now), .cmp_in(cmp_in), .all_power_lost(all_power_lost), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .backup_mode(backup_mode),
    .serial_en(serial_en), .io_en(io_en), .temp_run(temp_run), .bat_meas(bat_meas),
    .brownout_level(brownout_level));
  bps_host u_bps_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [39:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return {seed[7:0], seed};
  endfunction
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic results();
    $display("tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rdx(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_bps_host.rd_reg(a);
  endtask
  task automatic waitm(input logic v);
    for (int i = 0; i < 200 && backup_mode !== v; i++) @(posedge clk);
    if (backup_mode !== v) begin
      errors++;
      results();
    end
  endtask
  // one full power cycle; register port is refused while on battery
  task automatic pcyc(input logic [39:0] a, input logic [39:0] b, input logic io, tr);
    time_now <= a;
    cmp_in   <= 7'h60;
    waitm(1'b1);
    wt(4);
    chk(8'(io_en), 8'(io));
    chk(8'(temp_run), 8'(tr));
    chk(8'(bat_meas), 8'h00);
    rdx(bps_pkg::REG_STATUS, 8'h00);
    time_now <= b;
    cmp_in   <= 7'h10;
    waitm(1'b0);
    wt(4);
    chk(8'(bat_meas), 8'h01);
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d) chk(rdata, exp_q.pop_front());
    rd_d <= rd;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0; rst = 1; time_now = '0; cmp_in = '0; all_power_lost = 0;
    seed = 32'h0000_667b; errors = 0; tests_run = 0;
    ta = rnd(); tb = rnd(); tc = rnd(); td = rnd();
    wt(16);
    rst <= 1'b0;
    wt(1);
    all_power_lost <= 1'b1;
    wt(1);
    all_power_lost <= 1'b0;
    rdx(bps_pkg::REG_STATUS, 8'h01);
    u_bps_host.wr_reg(bps_pkg::REG_STATUS, 8'h01);
    rdx(bps_pkg::REG_STATUS, 8'h00);
    $display("power fail test done");
    u_bps_host.wr_reg(bps_pkg::REG_MASK, 8'h08);
    u_bps_host.wr_reg(bps_pkg::REG_BATCFG, 8'h05);
    cmp_in <= 7'h04;
    wt(8);
    chk(8'(serial_en), 8'h01);
    chk(8'(irq), 8'h01);
    chk(8'(brownout_level), 8'h05);
    rdx(bps_pkg::REG_STATUS, 8'h08);
    cmp_in <= '0;
    wt(6);
    u_bps_host.wr_reg(bps_pkg::REG_STATUS, 8'h08);
    u_bps_host.wr_reg(bps_pkg::REG_MASK, 8'h00);
    $display("brownout test done");
    u_bps_host.wr_reg(bps_pkg::REG_COMP, 8'h80);
    cmp_in <= 7'h02;
    wt(8);
    rdx(bps_pkg::REG_STATUS, 8'h04);
    cmp_in <= 7'h03;
    wt(8);
    rdx(bps_pkg::REG_STATUS, 8'h06);
    cmp_in <= '0;
    wt(6);
    u_bps_host.wr_reg(bps_pkg::REG_STATUS, 8'h06);
    $display("battery test done");
    cmp_in <= 7'h60;
    wt(1);
    cmp_in <= 7'h20;
    wt(20);
    chk(8'(backup_mode), 8'h00);
    pcyc(ta, tb, 1'b1, 1'b0);
    rdx(bps_pkg::REG_STATUS, 8'h30);
    rdx(bps_pkg::REG_MODE, 8'h00);
    u_bps_host.wr_reg(bps_pkg::REG_CTRL, 8'h00);
    u_bps_host.wr_reg(bps_pkg::REG_COMP, 8'hc0);
    pcyc(tc, td, 1'b0, 1'b1);
    rdx(bps_pkg::REG_V2B0, ta[7:0]);
    rdx(bps_pkg::REG_V2B0 + 4'h4, ta[39:32]);
    rdx(bps_pkg::REG_B2V0, td[7:0]);
    u_bps_host.wr_reg(bps_pkg::REG_CTRL, 8'h05);
    rdx(bps_pkg::REG_V2B0, 8'h00);
    rdx(bps_pkg::REG_B2V0 + 4'h4, 8'h00);
    rdx(bps_pkg::REG_CTRL, 8'h04);
    $display("switchover test done");
    wt(4);
    results();
  end
endmodule
